// >>> common/bwm_pkg.sv
// Package of offsets, field positions, opcodes and reset values for the move and add datapath.
package bwm_pkg;

    // ------------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_DST    = 8'h04;
    localparam logic [7:0] ADDR_SRC    = 8'h08;
    localparam logic [7:0] ADDR_WDST   = 8'h0C;
    localparam logic [7:0] ADDR_WSRC   = 8'h10;
    localparam logic [7:0] ADDR_PSW    = 8'h14;
    localparam logic [7:0] ADDR_FMODE  = 8'h18;
    localparam logic [7:0] ADDR_SAVE   = 8'h1C;
    localparam logic [7:0] ADDR_STATUS = 8'h20;

    // ------------------------------------------------------------------
    // Control word fields
    // ------------------------------------------------------------------
    localparam int CTRL_OP_LSB  = 0;
    localparam int CTRL_GO_BIT  = 3;
    localparam int CTRL_ACC_BIT = 4;
    localparam int CTRL_EEP_BIT = 5;

    localparam logic [2:0] OP_MOVE     = 3'h0;
    localparam logic [2:0] OP_MOVE_PSW = 3'h1;
    localparam logic [2:0] OP_EXCH     = 3'h2;
    localparam logic [2:0] OP_WMOVE    = 3'h3;
    localparam logic [2:0] OP_ADD      = 3'h4;
    localparam logic [2:0] OP_BYTE_SUM_WITH_CARRY_IN     = 3'h5;
    localparam logic [2:0] OP_FLAGS    = 3'h6;
    localparam logic [2:0] OP_NOP      = 3'h7;

    // ------------------------------------------------------------------
    // Program status word flag positions and flag update modes
    // ------------------------------------------------------------------
    localparam int PSW_CY_BIT = 0;
    localparam int PSW_AC_BIT = 4;
    localparam int PSW_Z_BIT  = 6;

    localparam logic [2:0] FM_KEEP    = 3'h0;
    localparam logic [2:0] FM_ZERO    = 3'h1;
    localparam logic [2:0] FM_ONE     = 3'h2;
    localparam logic [2:0] FM_RESULT  = 3'h3;
    localparam logic [2:0] FM_RESTORE = 3'h4;

    // Mode fields in the flag mode register: carry, nibble carry, zero.
    localparam int FMODE_CY_LSB = 0;
    localparam int FMODE_AC_LSB = 4;
    localparam int FMODE_Z_LSB  = 8;

    localparam int STAT_EEP_BIT = 0;
    localparam int STAT_BLK_BIT = 1;

    localparam logic [7:0]  RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;

endpackage

// >>> hw/bwm_byte_adder.sv
// Eight-bit adder with carry in, giving sum, carry out of bit 7 and carry from bit 3 into bit 4.
`timescale 1ns/1ps
module bwm_byte_adder
    import bwm_pkg::*;
(
    input  wire logic [7:0] a,
    input  wire logic [7:0] b,
    input  wire logic       cin,
    output logic      [7:0] sum,
    output logic            cy,
    output logic            ac
);
    logic [4:0] lo;
    logic [8:0] full;

    always_comb
    begin
        lo   = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        sum  = full[7:0];
        cy   = full[8];
        ac   = lo[4];
    end
endmodule

// >>> hw/bwm_flag_update.sv
// Applies one of five update modes to a single status flag.
`timescale 1ns/1ps
module bwm_flag_update
    import bwm_pkg::*;
(
    input  wire logic [2:0] mode,
    input  wire logic       cur,
    input  wire logic       res,
    input  wire logic       saved,
    output logic            flag
);
    function automatic logic upd(input logic [2:0] m, input logic c, input logic r,
                                 input logic s);
        case (m)
            FM_ZERO:    upd = 1'b0;
            FM_ONE:     upd = 1'b1;
            FM_RESULT:  upd = r;
            FM_RESTORE: upd = s;
            default:    upd = c;
        endcase
    endfunction

    always_comb
    begin
        flag = upd(mode, cur, res, saved);
    end
endmodule

// >>> hw/byte_word_move_add_datapath.sv
// Move, exchange, word move and add datapath with flag update and interrupt blocking.
//
// Summary of operation
// - A byte move copies the source byte into the destination and leaves the source as it was.
// - A byte move into the status word from an immediate or the accumulator rewrites the flags; any other byte move keeps them.
// - After a byte move into the status word no interrupt or macro service is acknowledged until the next instruction other than a status word load has run.
// - A byte exchange swaps its two operands and keeps every flag.
// - A word move copies sixteen bits from source to destination and keeps every flag.
// - A word store from the word accumulator into the EEPROM region is not carried out.
// - A byte add writes destination plus source back to the destination and puts the carry out in the carry flag.
// - A byte add with carry adds source, destination and the carry flag at the lowest bit and writes the byte back.
// - Both adds set the zero flag when the written byte is zero and clear it otherwise.
// - Both adds set the carry flag when a carry leaves bit 7 and clear it otherwise.
// - Both adds set the nibble carry flag when a carry passes from bit 3 into bit 4 and clear it otherwise.
// - Each flag can be kept, forced to zero, forced to one, set from the result or restored from a saved value.
`timescale 1ns/1ps
module byte_word_move_add_datapath
    import bwm_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic [7:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    input  wire logic        irq_req,
    input  wire logic        ms_req,
    output logic      [15:0] rdata,
    output logic      [7:0]  program_status_word,
    output logic             irq_ack,
    output logic             ms_ack,
    output logic             exec_done
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  dst_r;
        logic [7:0]  src_r;
        logic [15:0] wdst_r;
        logic [15:0] wsrc_r;
        logic [7:0]  psw_r;
        logic [11:0] fmode_r;
        logic [7:0]  save_r;
        logic        eep_err_r;
        logic        blk_r;
        logic [2:0]  last_op_r;
        logic [15:0] rdata_r;
        logic        irq_ack_r;
        logic        ms_ack_r;
        logic        done_r;
    } state_t;

    state_t s;
    state_t n;

    logic        go_w;
    logic [2:0]  op_w;
    logic        acc_sel_w;
    logic        eep_w;
    logic [7:0]  psw_src_w;
    logic [7:0]  sum_w;
    logic        sum_cy_w;
    logic        sum_ac_w;
    logic        cin_w;
    logic [2:0]  m_cy_w;
    logic [2:0]  m_ac_w;
    logic [2:0]  m_z_w;
    logic [7:0]  saved_w;
    logic        f_cy_w;
    logic        f_ac_w;
    logic        f_z_w;

    assign go_w      = wr_en && (addr == ADDR_CTRL) && wdata[CTRL_GO_BIT];
    assign op_w      = wdata[CTRL_OP_LSB +: 3];
    assign acc_sel_w = wdata[CTRL_ACC_BIT];
    assign eep_w     = wdata[CTRL_EEP_BIT];
    // The destination byte doubles as the accumulator for a status word load.
    assign psw_src_w = acc_sel_w ? s.dst_r : s.src_r;
    assign cin_w     = (op_w == OP_BYTE_SUM_WITH_CARRY_IN) ? s.psw_r[PSW_CY_BIT] : 1'b0;

    bwm_byte_adder u_adder (
        .a   (s.dst_r),
        .b   (s.src_r),
        .cin (cin_w),
        .sum (sum_w),
        .cy  (sum_cy_w),
        .ac  (sum_ac_w)
    );

    // ------------------------------------------------------------------
    // Flag mode selection per instruction
    // ------------------------------------------------------------------
    always_comb
    begin
        m_cy_w  = FM_KEEP;
        m_ac_w  = FM_KEEP;
        m_z_w   = FM_KEEP;
        saved_w = s.save_r;
        if (go_w)
        begin
            if (op_w == OP_ADD || op_w == OP_BYTE_SUM_WITH_CARRY_IN)
            begin
                m_cy_w = FM_RESULT;
                m_ac_w = FM_RESULT;
                m_z_w  = FM_RESULT;
            end
            else if (op_w == OP_MOVE_PSW)
            begin
                m_cy_w  = FM_RESTORE;
                m_ac_w  = FM_RESTORE;
                m_z_w   = FM_RESTORE;
                saved_w = psw_src_w;
            end
            else if (op_w == OP_FLAGS)
            begin
                m_cy_w = s.fmode_r[FMODE_CY_LSB +: 3];
                m_ac_w = s.fmode_r[FMODE_AC_LSB +: 3];
                m_z_w  = s.fmode_r[FMODE_Z_LSB +: 3];
            end
        end
    end

    bwm_flag_update u_f_cy (
        .mode  (m_cy_w),
        .cur   (s.psw_r[PSW_CY_BIT]),
        .res   (sum_cy_w),
        .saved (saved_w[PSW_CY_BIT]),
        .flag  (f_cy_w)
    );

    bwm_flag_update u_f_ac (
        .mode  (m_ac_w),
        .cur   (s.psw_r[PSW_AC_BIT]),
        .res   (sum_ac_w),
        .saved (saved_w[PSW_AC_BIT]),
        .flag  (f_ac_w)
    );

    bwm_flag_update u_f_z (
        .mode  (m_z_w),
        .cur   (s.psw_r[PSW_Z_BIT]),
        .res   (sum_w == 8'h00),
        .saved (saved_w[PSW_Z_BIT]),
        .flag  (f_z_w)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        n           = s;
        n.done_r    = 1'b0;
        n.rdata_r   = RST_WORD;
        n.psw_r[PSW_CY_BIT] = f_cy_w;
        n.psw_r[PSW_AC_BIT] = f_ac_w;
        n.psw_r[PSW_Z_BIT]  = f_z_w;
        // Acknowledge is decided from the blocking state held before this cycle.
        n.irq_ack_r = irq_req && !s.blk_r;
        n.ms_ack_r  = ms_req && !s.blk_r;

        if (wr_en)
        begin
            if (addr == ADDR_DST)
                n.dst_r = wdata[7:0];
            else if (addr == ADDR_SRC)
                n.src_r = wdata[7:0];
            else if (addr == ADDR_WDST)
                n.wdst_r = wdata;
            else if (addr == ADDR_WSRC)
                n.wsrc_r = wdata;
            else if (addr == ADDR_FMODE)
                n.fmode_r = wdata[11:0];
            else if (addr == ADDR_SAVE)
                n.save_r = wdata[7:0];
            else if (addr == ADDR_STATUS && wdata[STAT_EEP_BIT])
                n.eep_err_r = 1'b0;
        end

        if (go_w)
        begin
            n.last_op_r = op_w;
            n.done_r    = 1'b1;
            // Any executed instruction other than another status word load ends the window opened by a status word load.
            n.blk_r     = (op_w == OP_MOVE_PSW);
            case (op_w)
                OP_MOVE:
                    n.dst_r = s.src_r;
                OP_MOVE_PSW:
                    n.psw_r = psw_src_w;
                OP_EXCH:
                begin
                    // Both sides come from the old state, so the swap is exact.
                    n.dst_r = s.src_r;
                    n.src_r = s.dst_r;
                end
                OP_WMOVE:
                begin
                    if (eep_w)
                        n.eep_err_r = 1'b1;
                    else
                        n.wdst_r = s.wsrc_r;
                end
                OP_ADD,
                OP_BYTE_SUM_WITH_CARRY_IN:
                    n.dst_r = sum_w;
                default:
                    n.dst_r = s.dst_r;
            endcase
        end

        if (rd_en)
        begin
            if (addr == ADDR_CTRL)
                n.rdata_r = {13'h0000, s.last_op_r};
            else if (addr == ADDR_DST)
                n.rdata_r = {8'h00, s.dst_r};
            else if (addr == ADDR_SRC)
                n.rdata_r = {8'h00, s.src_r};
            else if (addr == ADDR_WDST)
                n.rdata_r = s.wdst_r;
            else if (addr == ADDR_WSRC)
                n.rdata_r = s.wsrc_r;
            else if (addr == ADDR_PSW)
                n.rdata_r = {8'h00, s.psw_r};
            else if (addr == ADDR_FMODE)
                n.rdata_r = {4'h0, s.fmode_r};
            else if (addr == ADDR_SAVE)
                n.rdata_r = {8'h00, s.save_r};
            else if (addr == ADDR_STATUS)
                n.rdata_r = {14'h0000, s.blk_r, s.eep_err_r};
            else
                n.rdata_r = RST_WORD;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            s <= '0;
        else
            s <= n;
    end

    assign rdata     = s.rdata_r;
    assign program_status_word       = s.psw_r;
    assign irq_ack   = s.irq_ack_r;
    assign ms_ack    = s.ms_ack_r;
    assign exec_done = s.done_r;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    property p_move;
        go_w && op_w == OP_MOVE |=> s.dst_r == $past(s.src_r) && s.src_r == $past(s.src_r);
    endproperty
    a_move: assert property (p_move) else $error("byte move result wrong");

    property p_move_keep;
        go_w && (op_w == OP_MOVE || op_w == OP_EXCH) |=> $stable(s.psw_r);
    endproperty
    a_move_keep: assert property (p_move_keep) else $error("flags changed by move");

    property p_psw_load;
        go_w && op_w == OP_MOVE_PSW && !acc_sel_w |=> s.psw_r == $past(s.src_r);
    endproperty
    a_psw_load: assert property (p_psw_load) else $error("status word load wrong");

    property p_block;
        go_w && op_w == OP_MOVE_PSW |=> s.blk_r ##1 !s.irq_ack_r && !s.ms_ack_r;
    endproperty
    a_block: assert property (p_block) else $error("acknowledge inside blocked window");

    property p_exch;
        go_w && op_w == OP_EXCH |=> s.dst_r == $past(s.src_r) && s.src_r == $past(s.dst_r);
    endproperty
    a_exch: assert property (p_exch) else $error("exchange not exact");

    property p_wmove;
        go_w && op_w == OP_WMOVE && !eep_w |=> s.wdst_r == $past(s.wsrc_r) && $stable(s.psw_r);
    endproperty
    a_wmove: assert property (p_wmove) else $error("word move wrong");

    property p_eeprom;
        go_w && op_w == OP_WMOVE && eep_w |=> $stable(s.wdst_r) && s.eep_err_r;
    endproperty
    a_eeprom: assert property (p_eeprom) else $error("EEPROM word store not refused");

    property p_add;
        go_w && op_w == OP_ADD
        |=> {s.psw_r[PSW_CY_BIT], s.dst_r} == {1'b0, $past(s.dst_r)} + {1'b0, $past(s.src_r)};
    endproperty
    a_add: assert property (p_add) else $error("add result or carry wrong");

    property p_byte_sum_with_carry_in;
        go_w && op_w == OP_BYTE_SUM_WITH_CARRY_IN
        |=> s.dst_r == 8'($past(s.dst_r) + $past(s.src_r) + {7'h00, $past(s.psw_r[PSW_CY_BIT])});
    endproperty
    a_byte_sum_with_carry_in: assert property (p_byte_sum_with_carry_in) else $error("add with carry result wrong");

    property p_zero;
        go_w && (op_w == OP_ADD || op_w == OP_BYTE_SUM_WITH_CARRY_IN) |=> s.psw_r[PSW_Z_BIT] == (s.dst_r == 8'h00);
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong");

    property p_nibble;
        go_w && op_w == OP_ADD
        |=> s.psw_r[PSW_AC_BIT] == (({1'b0, $past(s.dst_r[3:0])} + {1'b0, $past(s.src_r[3:0])})
                                    > 5'h0F);
    endproperty
    a_nibble: assert property (p_nibble) else $error("nibble carry wrong");

    property p_forced;
        go_w && op_w == OP_FLAGS && s.fmode_r[FMODE_CY_LSB +: 3] == FM_ONE
        |=> s.psw_r[PSW_CY_BIT];
    endproperty
    a_forced: assert property (p_forced) else $error("forced flag wrong");

    c_psw_then_irq: cover property (go_w && op_w == OP_MOVE_PSW ##1 irq_req ##1 go_w);
    c_byte_sum_with_carry_in_carry:   cover property (go_w && op_w == OP_BYTE_SUM_WITH_CARRY_IN && s.psw_r[PSW_CY_BIT]);
    c_exch:         cover property (go_w && op_w == OP_EXCH);
    c_eeprom:       cover property (go_w && op_w == OP_WMOVE && eep_w);
endmodule

// >>> tb/byte_word_move_add_datapath_tb.sv
// Self-checking bench for the move and add datapath against an integer model.
`timescale 1ns/1ps
module byte_word_move_add_datapath_tb;
    import bwm_pkg::*;

    // ------------------------------------------------------------------
    // Signals and model state
    // ------------------------------------------------------------------
    logic        clk_sys;
    logic        rst_n;
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr_en;
    logic        rd_en;
    logic        irq_req;
    logic        ms_req;
    logic [15:0] rdata;
    logic [7:0]  program_status_word;
    logic        irq_ack;
    logic        ms_ack;
    logic        exec_done;
    integer      mismatches;
    integer      checks_done;
    integer      seed;
    integer      cycles;
    integer      i;
    integer      m_dst, m_src, m_wdst, m_wsrc, m_psw, m_fm, m_save, m_err, m_blk;

    byte_word_move_add_datapath dut (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .addr      (addr),
        .wdata     (wdata),
        .wr_en     (wr_en),
        .rd_en     (rd_en),
        .irq_req   (irq_req),
        .ms_req    (ms_req),
        .rdata     (rdata),
        .program_status_word       (program_status_word),
        .irq_ack   (irq_ack),
        .ms_ack    (ms_ack),
        .exec_done (exec_done)
    );

    initial clk_sys = 1'b0;
    always #2.5 clk_sys = ~clk_sys;

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic summarize;
        if (mismatches == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // The run is tiny, so a hang is cut well before any slow simulator would notice.
    always @(posedge clk_sys)
    begin
        cycles = cycles + 1;
        if (cycles == 5000)
        begin
            mismatches = mismatches + 1;
            summarize();
        end
    end

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks_done = checks_done + 1;
        if (got !== exp)
        begin
            mismatches = mismatches + 1;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk_sys);
        wr_en <= 1'b0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe, so they are sampled there.
    task automatic rd(input logic [7:0] a, input integer exp, input string name);
        @(posedge clk_sys);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        #1;
        chk(name, 16'(exp), rdata);
    endtask

    task automatic setop(input logic [7:0] d, input logic [7:0] s);
        wr(ADDR_DST, {8'h00, d});
        wr(ADDR_SRC, {8'h00, s});
        m_dst = d;
        m_src = s;
    endtask

    function automatic integer fl(input integer mode, input integer cur, input integer res,
                                  input integer sv);
        case (mode)
            0: fl = cur;
            1: fl = 0;
            2: fl = 1;
            3: fl = res;
            default: fl = sv;
        endcase
    endfunction

    // Model one instruction, issue it, then compare completion and flags.
    task automatic run(input logic [2:0] op, input logic acc, input logic eep);
        integer s;
        integer c;
        integer a;
        c = (op == OP_BYTE_SUM_WITH_CARRY_IN) ? m_psw % 2 : 0;
        s = m_dst + m_src + c;
        a = (m_dst % 16) + (m_src % 16) + c;
        case (op)
            OP_MOVE: m_dst = m_src;
            OP_MOVE_PSW: m_psw = acc ? m_dst : m_src;
            OP_EXCH:
            begin
                c = m_dst;
                m_dst = m_src;
                m_src = c;
            end
            OP_WMOVE: if (eep) m_err = 1; else m_wdst = m_wsrc;
            OP_ADD, OP_BYTE_SUM_WITH_CARRY_IN:
            begin
                m_dst = s % 256;
                m_psw = (m_psw & 8'hAE) | (s / 256) | (a / 16) * 16 | (m_dst == 0) * 64;
            end
            OP_FLAGS: m_psw = (m_psw & 8'hAE)
                | fl(m_fm % 8, m_psw % 2, s / 256, m_save % 2)
                | fl((m_fm / 16) % 8, (m_psw / 16) % 2, a / 16, (m_save / 16) % 2) * 16
                | fl((m_fm / 256) % 8, (m_psw / 64) % 2, s % 256 == 0, (m_save / 64) % 2) * 64;
            default: ;
        endcase
        m_blk = (op == OP_MOVE_PSW);
        wr(ADDR_CTRL, {10'h000, eep, acc, 1'b1, op});
        chk("exec_done", 16'h0001, {15'h0000, exec_done});
        chk("psw", 16'(m_psw), {8'h00, program_status_word});
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        {addr, wdata, wr_en, rd_en, irq_req, ms_req} = '0;
        {mismatches, checks_done, cycles} = '0;
        {m_dst, m_src, m_wdst, m_wsrc, m_psw, m_fm, m_save, m_err, m_blk} = '0;
        seed = 32'hC56F9FCF;
        rst_n = 1'b0;
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(ADDR_PSW, 0, "psw reset");
        rd(ADDR_DST, 0, "dst reset");
        wr(ADDR_PSW, 16'h00FF);
        rd(ADDR_PSW, 0, "psw read only");
        wr(8'h24, 16'hFFFF);
        rd(8'h24, 0, "unmapped");

        setop(8'hFF, 8'h01);
        run(OP_ADD, 1'b0, 1'b0);
        setop(8'h0F, 8'h00);
        run(OP_BYTE_SUM_WITH_CARRY_IN, 1'b0, 1'b0);
        rd(ADDR_DST, m_dst, "dst carry in");
        for (i = 0; i < 40; i++)
        begin
            setop(8'($random(seed)), 8'($random(seed)));
            run(i % 2 ? OP_BYTE_SUM_WITH_CARRY_IN : OP_ADD, 1'b0, 1'b0);
            rd(ADDR_DST, m_dst, "dst sum");
        end

        setop(8'($random(seed)), 8'($random(seed)));
        run(OP_MOVE, 1'b0, 1'b0);
        rd(ADDR_DST, m_dst, "move dst");
        rd(ADDR_SRC, m_src, "move src");
        setop(8'hA5, 8'h3C);
        run(OP_EXCH, 1'b0, 1'b0);
        rd(ADDR_DST, m_dst, "exch dst");
        rd(ADDR_SRC, m_src, "exch src");

        m_wsrc = $random(seed) & 16'hFFFF;
        wr(ADDR_WSRC, 16'(m_wsrc));
        run(OP_WMOVE, 1'b0, 1'b0);
        rd(ADDR_WDST, m_wdst, "word dst");
        m_wsrc = (m_wsrc ^ 16'hFFFF) & 16'hFFFF;
        wr(ADDR_WSRC, 16'(m_wsrc));
        run(OP_WMOVE, 1'b0, 1'b1);
        rd(ADDR_WDST, m_wdst, "word dst kept");
        rd(ADDR_STATUS, m_err, "eeprom err");
        wr(ADDR_STATUS, 16'h0001);
        m_err = 0;
        rd(ADDR_STATUS, 0, "eeprom err cleared");

        for (i = 0; i < 10; i++)
        begin
            m_fm = i < 5 ? i * 16'h0111 : ($random(seed) & 3) * 16'h0101 + 16'h0040;
            m_save = $random(seed) & 8'hFF;
            wr(ADDR_FMODE, 16'(m_fm));
            wr(ADDR_SAVE, 16'(m_save));
            setop(8'($random(seed)), 8'($random(seed)));
            run(OP_FLAGS, 1'b0, 1'b0);
            rd(ADDR_FMODE, m_fm, "flag modes");
            rd(ADDR_SAVE, m_save, "saved flags");
        end

        setop(8'h5A, 8'hC3);
        run(OP_MOVE_PSW, 1'b1, 1'b0);
        @(posedge clk_sys);
        irq_req <= 1'b1;
        ms_req  <= 1'b1;
        run(OP_NOP, 1'b0, 1'b0);
        @(posedge clk_sys);
        #1;
        chk("ack open", 16'h0003, {14'h0000, irq_ack, ms_ack});
        run(OP_MOVE_PSW, 1'b0, 1'b0);
        repeat (3)
        begin
            @(posedge clk_sys);
            #1;
            chk("ack blocked", 16'h0000, {14'h0000, irq_ack, ms_ack});
        end
        rd(ADDR_STATUS, 2, "blocked");
        chk("ack blocked", 16'h0000, {14'h0000, irq_ack, ms_ack});
        run(OP_NOP, 1'b0, 1'b0);
        @(posedge clk_sys);
        #1;
        chk("ack reopened", 16'h0003, {14'h0000, irq_ack, ms_ack});
        rd(ADDR_STATUS, 0, "unblocked");
        rd(ADDR_CTRL, OP_NOP, "last op");
        summarize();
    end
endmodule
